/* File: hdl/raus_ctl.sv */
// Controller end: APB registers that drive register exchanges on the link
`timescale 1ns/1ps
`default_nettype none
module raus_ctl
	import raus_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Process data link
	raus_if.ctl link
);
	logic [7:0] cb_q;
	logic [15:0] ow_q;
	logic out_valid_q;
	logic busy_q;
	logic done_q;
	logic [7:0] st_q;
	logic [15:0] iw_q;
	logic iw_valid_q;
	logic pready_q;
	logic [31:0] prdata_q;
	logic pslverr_q;

	// APB phases; the access phase is always one cycle
	wire setup = psel & ~penable & ~pready_q;
	wire access = psel & penable & pready_q;
	wire hit_ctrl = (paddr == APB_CTRL);
	wire hit_outw = (paddr == APB_OUTW);
	wire hit_stat = (paddr == APB_STAT);
	wire hit_inw = (paddr == APB_INW);
	wire mapped = hit_ctrl | hit_outw | hit_stat | hit_inw;
	wire refuse = pwrite & (hit_ctrl | hit_outw) & busy_q;
	wire bad = ~mapped | refuse;
	wire wr_ok = access & pwrite & ~pslverr_q;
	wire launch = wr_ok & hit_ctrl;
	wire [31:0] stat_word = {21'h000000, iw_valid_q, done_q, busy_q, st_q};
	wire [31:0] rd_mux =
		hit_ctrl ? {24'h000000, cb_q} :
		hit_outw ? {16'h0000, ow_q} :
		hit_stat ? stat_word :
		hit_inw ? {16'h0000, iw_q} : 32'h00000000;

	// Answer decode; a write acknowledge leaves the input word unused
	wire answer = link.in_valid & busy_q;
	wire was_write = cb_q[CB_REGMODE_BIT] & cb_q[CB_WRITE_BIT];

	// APB handshake
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup;
			if (setup) begin
				prdata_q <= pwrite ? 32'h00000000 : rd_mux;
				pslverr_q <= bad;
			end else if (access) begin
				pslverr_q <= 1'b0;
			end
		end
	end

	// Request registers and link drive
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cb_q <= 8'h00;
			ow_q <= 16'h0000;
			out_valid_q <= 1'b0;
		end else begin
			out_valid_q <= launch;
			if (launch) begin
				cb_q <= pwdata[7:0];
			end
			if (wr_ok & hit_outw) begin
				ow_q <= pwdata[15:0];
			end
		end
	end

	// Exchange tracking and captured answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			st_q <= 8'h00;
			iw_q <= 16'h0000;
			iw_valid_q <= 1'b0;
		end else if (launch) begin
			busy_q <= 1'b1;
			done_q <= 1'b0;
			iw_valid_q <= 1'b0;
		end else if (answer) begin
			busy_q <= 1'b0;
			done_q <= 1'b1;
			st_q <= link.status_byte;
			iw_valid_q <= ~was_write;
			if (!was_write) begin
				iw_q <= link.inbound_word;
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign link.ctrl_byte = cb_q;
	assign link.outbound_word = ow_q;
	assign link.out_valid = out_valid_q;
endmodule : raus_ctl
`default_nettype wire

/* File: hdl/raus_if.sv */
// Process data link between controller and terminal
`timescale 1ns/1ps
`default_nettype none
interface raus_if;
	logic [7:0] ctrl_byte;
	logic [15:0] outbound_word;
	logic out_valid;
	logic [7:0] status_byte;
	logic [15:0] inbound_word;
	logic in_valid;
	modport dev (
		input ctrl_byte,
		input outbound_word,
		input out_valid,
		output status_byte,
		output inbound_word,
		output in_valid
	);
	modport ctl (
		output ctrl_byte,
		output outbound_word,
		output out_valid,
		input status_byte,
		input inbound_word,
		input in_valid
	);
endinterface : raus_if
`default_nettype wire

/* File: hdl/raus_pkg.sv */
// Shared constants for the register link between terminal and controller
package raus_pkg;
	// Clock and time base
	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_NS = 1000000;
	localparam int CLR_UNIT_MS = 10;
	localparam int CYC_PER_MS_DFLT = MS_NS / CLK_PERIOD_NS;
	localparam int CYC_PER_CLR_DFLT = CLR_UNIT_MS * CYC_PER_MS_DFLT;
	// Control and status byte fields
	localparam int CB_REGMODE_BIT = 7;
	localparam int CB_WRITE_BIT = 6;
	localparam int CB_ADDR_W = 6;
	localparam int SB_UV_BIT = 6;
	localparam logic [7:0] CB_WRITE_MASK = 8'h40;
	// Terminal register numbers
	localparam logic [5:0] REG_FW = 6'h09;
	localparam logic [5:0] REG_UNLOCK = 6'h1f;
	localparam logic [5:0] REG_FEATURE = 6'h20;
	localparam logic [5:0] REG_ESCALE = 6'h23;
	localparam logic [5:0] REG_UVTH = 6'h24;
	localparam logic [5:0] REG_DIV = 6'h25;
	localparam logic [5:0] REG_CLRT = 6'h26;
	localparam logic [5:0] REG_MCYC = 6'h27;
	// Unlock code and register reset values
	localparam logic [15:0] UNLOCK_CODE = 16'h1235;
	localparam logic [15:0] UNLOCK_RST = 16'h0000;
	localparam logic [15:0] FEATURE_RST = 16'h0020;
	localparam logic [15:0] FEATURE_MASK = 16'h00fd;
	localparam logic [15:0] ESCALE_RST = 16'h0004;
	localparam logic [15:0] ESCALE_MAX = 16'h0006;
	localparam logic [15:0] UVTH_RST = 16'h0064;
	localparam logic [15:0] DIV_RST = 16'h0001;
	localparam logic [15:0] CLRT_RST = 16'h00c8;
	localparam logic [15:0] MCYC_RST = 16'h0032;
	// Arbitrary neutral firmware code, two ASCII characters
	localparam logic [15:0] FW_VERSION_DFLT = 16'h3030;
	// Feature register bits
	localparam int FEAT_RATIO_BIT = 0;
	localparam int FEAT_AUTOCLR_BIT = 7;
	// Controller APB map
	localparam logic [11:0] APB_CTRL = 12'h000;
	localparam logic [11:0] APB_OUTW = 12'h004;
	localparam logic [11:0] APB_STAT = 12'h008;
	localparam logic [11:0] APB_INW = 12'h00c;
	localparam int ST_BUSY_BIT = 8;
	localparam int ST_DONE_BIT = 9;
	localparam int ST_INW_VALID_BIT = 10;
endpackage : raus_pkg

/* File: hdl/raus_terminal.sv */
// Terminal end: register access over process data and user settings
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Control bit 7 selects register access
// - Control bit 6: clear reads, set writes
// - Low six control bits give register number
// - Read echoes control byte, returns register word
// - Write acknowledged with bit 6 cleared
// - Controller ignores input word after write
// - Output word ignored on read, data on write
// - User registers protected; unlock word always writable
// - Writing 0x1235 to unlock word lifts protection
// - Any other unlock value restores protection
// - User register changes act only after restart; unlock word acts at once
// - Energy scaling entries 0..6, default 4
// - Controller unlocks before changing energy scaling
// - Voltage below threshold sets error bit, indicator
// - Ratio enable divides current by divisor
// - Apply ratio in terminal only below 65535; the code divides whenever ratio is enabled
// - Auto-clear min/max after programmed 10 ms units
// - Measuring interval in 1 ms steps
// - Firmware version returned as two ASCII bytes
// - Restart clears the unlock word
// - Ratio one over divisor, else one to one
module raus_terminal
	import raus_pkg::*;
#(
	parameter int CYC_PER_MS = CYC_PER_MS_DFLT,
	parameter int CYC_PER_CLR = CYC_PER_CLR_DFLT,
	parameter logic [15:0] FW_VERSION = FW_VERSION_DFLT
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Process data link
	raus_if.dev link,
	// Measurement side
	input wire logic restart,
	input wire logic [15:0] mains_voltage,
	input wire logic [15:0] current_raw,
	// Settings and indications
	output logic undervoltage_error_flag,
	output logic error_led,
	output logic [15:0] current_scaled,
	output logic [2:0] energy_scale,
	output logic [15:0] feature_active,
	output logic measure_tick,
	output logic minmax_clear
);
	localparam int MS_W = $clog2(CYC_PER_MS + 1);
	localparam int CLR_W = $clog2(CYC_PER_CLR + 1);

	// Stored values, as read back over the link
	logic [15:0] unlock_q;
	logic [15:0] feature_q;
	logic [15:0] escale_q;
	logic [15:0] uvth_q;
	logic [15:0] div_q;
	logic [15:0] clrt_q;
	logic [15:0] mcyc_q;
	// Values in force, loaded at restart
	logic [15:0] feature_act_q;
	logic [15:0] escale_act_q;
	logic [15:0] uvth_act_q;
	logic [15:0] div_act_q;
	logic [15:0] clrt_act_q;
	logic [15:0] mcyc_act_q;
	// Link answer
	logic [7:0] status_q;
	logic [15:0] inbound_q;
	logic in_valid_q;
	// Measurement side
	logic uv_q;
	logic led_q;
	logic [15:0] cur_q;
	logic [MS_W-1:0] ms_cnt_q;
	logic [15:0] mc_cnt_q;
	logic tick_q;
	logic [CLR_W-1:0] cu_cnt_q;
	logic [15:0] cl_cnt_q;
	logic clr_q;

	// Request decode
	wire reg_req = link.out_valid & link.ctrl_byte[CB_REGMODE_BIT];
	wire is_wr = link.ctrl_byte[CB_WRITE_BIT];
	wire [5:0] reg_num = link.ctrl_byte[CB_ADDR_W-1:0];
	wire wr_req = reg_req & is_wr;
	wire rd_req = reg_req & ~is_wr;
	wire [15:0] wdata = link.outbound_word;
	wire unlocked = (unlock_q == UNLOCK_CODE);
	wire user_wr = wr_req & unlocked;
	wire wr_unlock = wr_req & (reg_num == REG_UNLOCK);
	wire wr_feature = user_wr & (reg_num == REG_FEATURE);
	wire wr_escale = user_wr & (reg_num == REG_ESCALE) & (wdata <= ESCALE_MAX);
	wire wr_uvth = user_wr & (reg_num == REG_UVTH);
	wire wr_div = user_wr & (reg_num == REG_DIV);
	wire wr_clrt = user_wr & (reg_num == REG_CLRT);
	wire wr_mcyc = user_wr & (reg_num == REG_MCYC);

	// Read selection; unmapped numbers read zero
	wire [15:0] rd_data =
		(reg_num == REG_FW) ? FW_VERSION :
		(reg_num == REG_UNLOCK) ? unlock_q :
		(reg_num == REG_FEATURE) ? feature_q :
		(reg_num == REG_ESCALE) ? escale_q :
		(reg_num == REG_UVTH) ? uvth_q :
		(reg_num == REG_DIV) ? div_q :
		(reg_num == REG_CLRT) ? clrt_q :
		(reg_num == REG_MCYC) ? mcyc_q : 16'h0000;

	// Answer selection
	wire [7:0] ack_byte = link.ctrl_byte & ~CB_WRITE_MASK;
	wire [7:0] pd_status = {1'b0, uv_q, 6'h00};

	// Current scaling; a zero divisor counts as one
	wire [15:0] div_eff = (div_act_q == 16'h0000) ? 16'h0001 : div_act_q;
	wire ratio_on = feature_act_q[FEAT_RATIO_BIT];
	wire [15:0] cur_d = ratio_on ? (current_raw / div_eff) : current_raw;

	// Timer limits; a zero setting counts as one unit
	wire ms_end = (ms_cnt_q == MS_W'(CYC_PER_MS - 1));
	wire [15:0] mc_lim = (mcyc_act_q == 16'h0000) ? 16'h0001 : mcyc_act_q;
	wire mc_end = ms_end & (mc_cnt_q >= mc_lim - 16'h0001);
	wire autoclr_on = feature_act_q[FEAT_AUTOCLR_BIT];
	wire cu_end = (cu_cnt_q == CLR_W'(CYC_PER_CLR - 1));
	wire [15:0] cl_lim = (clrt_act_q == 16'h0000) ? 16'h0001 : clrt_act_q;
	wire cl_end = cu_end & (cl_cnt_q >= cl_lim - 16'h0001);

	// Unlock word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unlock_q <= UNLOCK_RST;
		end else if (restart) begin
			unlock_q <= UNLOCK_RST;
		end else if (wr_unlock) begin
			unlock_q <= wdata;
		end
	end

	// Stored user registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			feature_q <= FEATURE_RST;
			escale_q <= ESCALE_RST;
			uvth_q <= UVTH_RST;
			div_q <= DIV_RST;
			clrt_q <= CLRT_RST;
			mcyc_q <= MCYC_RST;
		end else begin
			if (wr_feature) begin
				feature_q <= wdata & FEATURE_MASK;
			end
			if (wr_escale) begin
				escale_q <= wdata;
			end
			if (wr_uvth) begin
				uvth_q <= wdata;
			end
			if (wr_div) begin
				div_q <= wdata;
			end
			if (wr_clrt) begin
				clrt_q <= wdata;
			end
			if (wr_mcyc) begin
				mcyc_q <= wdata;
			end
		end
	end

	// Values in force change only at restart
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			feature_act_q <= FEATURE_RST;
			escale_act_q <= ESCALE_RST;
			uvth_act_q <= UVTH_RST;
			div_act_q <= DIV_RST;
			clrt_act_q <= CLRT_RST;
			mcyc_act_q <= MCYC_RST;
		end else if (restart) begin
			feature_act_q <= feature_q;
			escale_act_q <= escale_q;
			uvth_act_q <= uvth_q;
			div_act_q <= div_q;
			clrt_act_q <= clrt_q;
			mcyc_act_q <= mcyc_q;
		end
	end

	// Link answer, one cycle after the exchange
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q <= 8'h00;
			inbound_q <= 16'h0000;
			in_valid_q <= 1'b0;
		end else begin
			in_valid_q <= link.out_valid;
			if (rd_req) begin
				status_q <= link.ctrl_byte;
				inbound_q <= rd_data;
			end else if (wr_req) begin
				status_q <= ack_byte;
			end else if (link.out_valid) begin
				status_q <= pd_status;
				inbound_q <= cur_q;
			end
		end
	end

	// Undervoltage check and scaled current
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			uv_q <= 1'b0;
			led_q <= 1'b0;
			cur_q <= 16'h0000;
		end else begin
			uv_q <= (mains_voltage < uvth_act_q);
			led_q <= (mains_voltage < uvth_act_q);
			cur_q <= cur_d;
		end
	end

	// Measuring interval timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_cnt_q <= '0;
			mc_cnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end else begin
			ms_cnt_q <= ms_end ? '0 : ms_cnt_q + MS_W'(1);
			tick_q <= mc_end;
			if (mc_end) begin
				mc_cnt_q <= 16'h0000;
			end else if (ms_end) begin
				mc_cnt_q <= mc_cnt_q + 16'h0001;
			end
		end
	end

	// Min/max auto-clear timer, idle while disabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cu_cnt_q <= '0;
			cl_cnt_q <= 16'h0000;
			clr_q <= 1'b0;
		end else if (!autoclr_on) begin
			cu_cnt_q <= '0;
			cl_cnt_q <= 16'h0000;
			clr_q <= 1'b0;
		end else begin
			cu_cnt_q <= cu_end ? '0 : cu_cnt_q + CLR_W'(1);
			clr_q <= cl_end;
			if (cl_end) begin
				cl_cnt_q <= 16'h0000;
			end else if (cu_end) begin
				cl_cnt_q <= cl_cnt_q + 16'h0001;
			end
		end
	end

	assign link.status_byte = status_q;
	assign link.inbound_word = inbound_q;
	assign link.in_valid = in_valid_q;
	assign undervoltage_error_flag = uv_q;
	assign error_led = led_q;
	assign current_scaled = cur_q;
	assign energy_scale = escale_act_q[2:0];
	assign feature_active = feature_act_q;
	assign measure_tick = tick_q;
	assign minmax_clear = clr_q;
endmodule : raus_terminal
`default_nettype wire

/* File: testbench/raus_chk.sv */
// Concurrent checks on the process data link between the two ends
`timescale 1ns/1ps
`default_nettype none
module raus_chk
	import raus_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Link signals
	input wire logic [7:0] ctrl_byte,
	input wire logic [15:0] outbound_word,
	input wire logic out_valid,
	input wire logic [7:0] status_byte,
	input wire logic [15:0] inbound_word,
	input wire logic in_valid
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_read;
		out_valid && ctrl_byte[7:6] == 2'b10;
	endsequence
	sequence s_write;
		out_valid && ctrl_byte[7:6] == 2'b11;
	endsequence
	a_answer_next: assert property (out_valid |=> in_valid)
		else $error("answer missing after request");
	a_answer_caused: assert property (in_valid |-> $past(out_valid))
		else $error("answer without request");
	a_req_spacing: assert property (out_valid |=> !out_valid [*2])
		else $error("requests too close");
	a_read_echo: assert property (s_read |=> status_byte == $past(ctrl_byte))
		else $error("read status not an echo");
	a_write_ack: assert property (s_write |=> status_byte == ($past(ctrl_byte) & ~CB_WRITE_MASK))
		else $error("write acknowledge wrong");
	a_fw_word: assert property (s_read ##0 (ctrl_byte[5:0] == REG_FW) |=>
		inbound_word == FW_VERSION_DFLT)
		else $error("firmware word wrong");
	a_answer_held: assert property (!in_valid |-> $stable(status_byte) && $stable(inbound_word))
		else $error("answer changed between exchanges");
	a_proc_status: assert property (out_valid && !ctrl_byte[7] |=>
		!status_byte[7] && status_byte[5:0] == 6'h00)
		else $error("process status has register bits");
endmodule : raus_chk
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench: controller and terminal joined over the link
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import raus_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, restart, pready, pslverr, uv, led, tick, mmc;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] mains_voltage, current_raw, cur, feat, iw;
	logic [7:0] st;
	logic [2:0] esc;
	logic iwv;
	int mismatches, check_count, cycles;
	raus_if link ();
	raus_ctl raus_ctl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .link(link.ctl));
	raus_terminal #(.CYC_PER_MS(4), .CYC_PER_CLR(40)) raus_terminal_inst (.pclk, .presetn,
		.link(link.dev), .restart, .mains_voltage, .current_raw, .undervoltage_error_flag(uv),
		.error_led(led), .current_scaled(cur), .energy_scale(esc), .feature_active(feat),
		.measure_tick(tick), .minmax_clear(mmc));
	raus_chk raus_chk_inst (.pclk, .presetn, .ctrl_byte(link.ctrl_byte),
		.outbound_word(link.outbound_word), .out_valid(link.out_valid),
		.status_byte(link.status_byte), .inbound_word(link.inbound_word),
		.in_valid(link.in_valid));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task end_sim;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_sim
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 6000) begin
			mismatches++;
			end_sim();
		end
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// One APB transfer; holds the request until pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		chk("pslverr", {31'h0, a > APB_INW}, {31'h0, pslverr});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task xchg(input logic [7:0] c, input logic [15:0] w);
		apb(1'b1, APB_OUTW, {16'h0, w});
		apb(1'b1, APB_CTRL, {24'h0, c});
		do begin
			apb(1'b0, APB_STAT, 32'h0);
		end while (rd[ST_DONE_BIT] !== 1'b1);
		st = rd[7:0];
		iwv = rd[ST_INW_VALID_BIT];
		apb(1'b0, APB_INW, 32'h0);
		iw = rd[15:0];
	endtask : xchg
	task wreg(input logic [5:0] a, input logic [15:0] d);
		xchg({2'b11, a}, d);
		chk("write ack", {24'h0, 2'b10, a}, {24'h0, st});
		chk("inbound valid", 32'h0, {31'h0, iwv});
	endtask : wreg
	task rreg(input logic [5:0] a, input logic [15:0] e);
		xchg({2'b10, a}, 16'hffff);
		chk("read echo", {24'h0, 2'b10, a}, {24'h0, st});
		chk("inbound valid", 32'h1, {31'h0, iwv});
		chk("register word", {16'h0, e}, {16'h0, iw});
	endtask : rreg
	task gap(input logic sel, input logic [31:0] e);
		int k;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while ((sel ? mmc : tick) !== 1'b1 && k < 300);
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while ((sel ? mmc : tick) !== 1'b1 && k < 300);
		chk("pulse period", e, 32'(k));
	endtask : gap
	task t_defaults;
		rreg(REG_FW, FW_VERSION_DFLT);
		rreg(REG_UNLOCK, 16'h0000);
		rreg(REG_FEATURE, 16'h0020);
		rreg(REG_ESCALE, 16'h0004);
		rreg(REG_UVTH, 16'h0064);
		rreg(REG_DIV, 16'h0001);
		rreg(REG_CLRT, 16'h00c8);
		rreg(REG_MCYC, 16'h0032);
		rreg(6'h3e, 16'h0000);
		chk("scaled current", 32'd1000, {16'h0, cur});
		chk("undervoltage", 32'h0, {31'h0, uv});
		apb(1'b0, 12'h010, 32'h0);
		$display("defaults done");
	endtask : t_defaults
	task t_locked;
		wreg(REG_UVTH, 16'h00aa);
		rreg(REG_UVTH, 16'h0064);
		wreg(REG_UNLOCK, 16'h1234);
		wreg(REG_ESCALE, 16'h0001);
		rreg(REG_ESCALE, 16'h0004);
		$display("locked done");
	endtask : t_locked
	task t_unlock;
		wreg(REG_UNLOCK, 16'h1235);
		rreg(REG_UNLOCK, 16'h1235);
		wreg(REG_UVTH, 16'h00c8);
		wreg(REG_FEATURE, 16'h0081);
		wreg(REG_DIV, 16'h0002);
		wreg(REG_ESCALE, 16'h0007);
		rreg(REG_ESCALE, 16'h0004);
		wreg(REG_ESCALE, 16'h0006);
		wreg(REG_CLRT, 16'h0001);
		wreg(REG_MCYC, 16'h0005);
		wreg(REG_UNLOCK, 16'h0000);
		wreg(REG_UVTH, 16'h0011);
		rreg(REG_UVTH, 16'h00c8);
		chk("feature in force", 32'h0020, {16'h0, feat});
		chk("energy in force", 32'h4, {29'h0, esc});
		$display("unlock done");
	endtask : t_unlock
	task t_restart;
		@(posedge pclk);
		restart <= 1'b1;
		@(posedge pclk);
		restart <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("feature in force", 32'h0081, {16'h0, feat});
		chk("energy in force", 32'h6, {29'h0, esc});
		chk("scaled current", 32'd500, {16'h0, cur});
		chk("undervoltage", 32'h1, {31'h0, uv});
		chk("error led", 32'h1, {31'h0, led});
		rreg(REG_UNLOCK, 16'h0000);
		xchg(8'h00, 16'h0000);
		chk("process status", 32'h40, {24'h0, st});
		chk("process word", 32'd500, {16'h0, iw});
		gap(1'b0, 32'd20);
		gap(1'b1, 32'd40);
		mains_voltage <= 16'd300;
		repeat (3) @(posedge pclk);
		chk("undervoltage", 32'h0, {31'h0, uv});
		$display("restart done");
	endtask : t_restart
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		restart = 1'b0;
		mains_voltage = 16'd150;
		current_raw = 16'd1000;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_defaults();
		t_locked();
		t_unlock();
		t_restart();
		end_sim();
	end
endmodule : testbench
`default_nettype wire
